/* shared/iowfd_pkg.sv */
/*
 * constants for the i/o window forwarding decoder: configuration
 * offsets, field positions, reset values and bus command codes.
 * assumes a 32-bit configuration dword port addressed by byte offset.
 */
// Overview of operation
// - in-range addresses go down; everything else goes up, no gaps
// - addresses pass unchanged; one flat space, no translation
// - i/o enable clear: every primary i/o transaction is ignored
// - master enable gates all secondary i/o and memory forwarding
// - i/o inside base..limit goes down; outside goes up
// - base above limit disables window: nothing down, all i/o up
// - base low twelve bits are zero, 4KB alignment
// - limit low twelve bits are all ones, top of 4KB block
// - base low byte: upper nibble is bits 15:12, lower nibble reads 1h
// - base upper half register, fully writable, gives bits 31:16
// - limit held like base: low byte nibble plus writable upper half
// - reset sets base to zero and limit to 0fffh
// - isa mode acts only in window and when address bits 31:16 are zero
// - isa on: in-window top 768 bytes of each 1KB below 64KB not sent downstream
// - isa and master enable: top 768 bytes below 64KB go upstream
// - at or above 64KB only the window comparison decides
package iowfd_pkg;

    // ------------------------------------------------------------------
    // configuration offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] IOWFD_BASE_LOW_OFF = 8'h1c;
    localparam logic [7:0] IOWFD_LIMIT_LOW_OFF = 8'h1d;
    localparam logic [7:0] IOWFD_BASE_UP_OFF = 8'h30;
    localparam logic [7:0] IOWFD_LIMIT_UP_OFF = 8'h32;

    // ------------------------------------------------------------------
    // field positions and fixed values
    // ------------------------------------------------------------------
    localparam int IOWFD_GRAN_LSB = 12;
    localparam int IOWFD_UPPER_LSB = 16;
    localparam int IOWFD_NIB_LSB = 4;
    localparam int IOWFD_ISA_HI = 9;
    localparam int IOWFD_ISA_LO = 8;
    localparam logic [3:0] IOWFD_CAP_32BIT = 4'h1;
    localparam logic [11:0] IOWFD_BASE_FILL = 12'h000;
    localparam logic [11:0] IOWFD_LIMIT_FILL = 12'hfff;
    localparam logic [15:0] IOWFD_LOW64K_UPPER = 16'h0000;

    // ------------------------------------------------------------------
    // reset values of the whole window addresses
    // ------------------------------------------------------------------
    localparam logic [31:0] IOWFD_BASE_RST = 32'h0000_0000;
    localparam logic [31:0] IOWFD_LIMIT_RST = 32'h0000_0fff;

    // ------------------------------------------------------------------
    // bus command codes
    // ------------------------------------------------------------------
    localparam logic [3:0] IOWFD_CMD_IO_RD = 4'h2;
    localparam logic [3:0] IOWFD_CMD_IO_WR = 4'h3;
    localparam logic [3:0] IOWFD_CMD_MEM_RD = 4'h6;
    localparam logic [3:0] IOWFD_CMD_MEM_WR = 4'h7;
    localparam logic [3:0] IOWFD_CMD_MEM_RDM = 4'hc;
    localparam logic [3:0] IOWFD_CMD_MEM_RDL = 4'he;
    localparam logic [3:0] IOWFD_CMD_MEM_WRI = 4'hf;

    // ------------------------------------------------------------------
    // timing: address phase to decision, in clock cycles
    // ------------------------------------------------------------------
    localparam int IOWFD_DEC_LATENCY = 1;

endpackage

/* shared/iowfd_cfg_if.sv */
/*
 * carrier between the decoder top and its window register file.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface iowfd_cfg_if;
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic rack;
    logic rhit;
    logic [31:0] base_addr;
    logic [31:0] limit_addr;

    modport regs (
        input wr, rd, addr, be, wdata,
        output rdata, rack, rhit, base_addr, limit_addr
    );
    modport dec (
        output wr, rd, addr, be, wdata,
        input rdata, rack, rhit, base_addr, limit_addr
    );
endinterface
`default_nettype wire

/* core/iowfd_window_regs.sv */
/*
 * i/o base and limit configuration registers with dword read/write.
 * assumes one access at a time, dword aligned byte offset, byte enables.
 */
`timescale 1ns/1ps
`default_nettype none
module iowfd_window_regs
    import iowfd_pkg::*;
(
    // clock and reset
    input wire logic mclk_in,
    input wire logic srst_in,
    // register side of the carrier
    iowfd_cfg_if.regs cfg
);

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    logic [3:0] base_nib_reg, base_nib_next;
    logic [3:0] limit_nib_reg, limit_nib_next;
    logic [15:0] base_up_reg, base_up_next;
    logic [15:0] limit_up_reg, limit_up_next;
    logic [31:0] rdata_reg, rdata_next;
    logic rack_reg, rack_next;
    logic rhit_reg, rhit_next;
    logic low_sel;
    logic up_sel;

    // dword selects
    assign low_sel = (cfg.addr[7:2] == IOWFD_BASE_LOW_OFF[7:2]);
    assign up_sel = (cfg.addr[7:2] == IOWFD_BASE_UP_OFF[7:2]);

    // next values of the fields and the read answer
    always_comb begin
        base_nib_next = base_nib_reg;
        limit_nib_next = limit_nib_reg;
        base_up_next = base_up_reg;
        limit_up_next = limit_up_reg;
        rdata_next = rdata_reg;
        rack_next = cfg.rd;
        rhit_next = rhit_reg;
        if (cfg.wr && low_sel) begin
            if (cfg.be[IOWFD_BASE_LOW_OFF[1:0]]) begin
                base_nib_next = cfg.wdata[7:4];
            end
            if (cfg.be[IOWFD_LIMIT_LOW_OFF[1:0]]) begin
                limit_nib_next = cfg.wdata[15:12];
            end
        end
        if (cfg.wr && up_sel) begin
            if (cfg.be[0]) base_up_next[7:0] = cfg.wdata[7:0];
            if (cfg.be[1]) base_up_next[15:8] = cfg.wdata[15:8];
            if (cfg.be[2]) limit_up_next[7:0] = cfg.wdata[23:16];
            if (cfg.be[3]) limit_up_next[15:8] = cfg.wdata[31:24];
        end
        if (cfg.rd) begin
            rhit_next = low_sel || up_sel;
            if (low_sel) begin
                // lower nibbles read back the 32-bit capability code
                rdata_next = {16'h0000, limit_nib_reg, IOWFD_CAP_32BIT,
                              base_nib_reg, IOWFD_CAP_32BIT};
            end else if (up_sel) begin
                rdata_next = {limit_up_reg, base_up_reg};
            end else begin
                rdata_next = 32'h0000_0000;
            end
        end
        if (srst_in) begin
            base_nib_next = IOWFD_BASE_RST[15:12];
            limit_nib_next = IOWFD_LIMIT_RST[15:12];
            base_up_next = IOWFD_BASE_RST[31:16];
            limit_up_next = IOWFD_LIMIT_RST[31:16];
            rdata_next = 32'h0000_0000;
            rack_next = 1'b0;
            rhit_next = 1'b0;
        end
    end

    // register stage
    always_ff @(posedge mclk_in) begin
        base_nib_reg <= base_nib_next;
        limit_nib_reg <= limit_nib_next;
        base_up_reg <= base_up_next;
        limit_up_reg <= limit_up_next;
        rdata_reg <= rdata_next;
        rack_reg <= rack_next;
        rhit_reg <= rhit_next;
    end

    // full window addresses with the implied low bits
    assign cfg.base_addr = {base_up_reg, base_nib_reg,
                            IOWFD_BASE_FILL};
    assign cfg.limit_addr = {limit_up_reg, limit_nib_reg,
                             IOWFD_LIMIT_FILL};
    assign cfg.rdata = rdata_reg;
    assign cfg.rack = rack_reg;
    assign cfg.rhit = rhit_reg;

endmodule
`default_nettype wire

/* core/iowfd_decoder.sv */
/*
 * i/o forwarding decoder of the bridge: judges each address phase on
 * the primary and secondary bus and says whether to claim and forward.
 * assumes address phases are single-cycle strobes synchronous to mclk_in
 * and that command, i/o enable, master enable and isa enable come from
 * the surrounding configuration logic as levels.
 */
`timescale 1ns/1ps
`default_nettype none
module iowfd_decoder
    import iowfd_pkg::*;
#(
    parameter int ADDR_W = 32
)
(
    // clock and reset
    input wire logic mclk_in,
    input wire logic srst_in,
    // configuration dword port
    input wire logic cfg_wr_in,
    input wire logic cfg_rd_in,
    input wire logic [7:0] cfg_addr_in,
    input wire logic [3:0] cfg_be_in,
    input wire logic [31:0] cfg_wdata_in,
    output logic [31:0] cfg_rdata_out,
    output logic cfg_rack_out,
    output logic cfg_rhit_out,
    // command and bridge control bits
    input wire logic io_enable_in,
    input wire logic master_enable_in,
    input wire logic isa_enable_in,
    // primary bus address phase
    input wire logic p_addr_valid_in,
    input wire logic [ADDR_W-1:0] p_addr_in,
    input wire logic [3:0] p_cmd_in,
    // primary decision
    output logic p_dec_valid_out,
    output logic p_claim_out,
    output logic p_isa_excl_out,
    output logic [ADDR_W-1:0] p_fwd_addr_out,
    output logic [3:0] p_fwd_cmd_out,
    // secondary bus address phase
    input wire logic s_addr_valid_in,
    input wire logic [ADDR_W-1:0] s_addr_in,
    input wire logic [3:0] s_cmd_in,
    // secondary decision
    output logic s_dec_valid_out,
    output logic s_claim_out,
    output logic s_mem_pass_out,
    output logic s_isa_excl_out,
    output logic [ADDR_W-1:0] s_fwd_addr_out,
    output logic [3:0] s_fwd_cmd_out,
    // window status
    output logic win_open_out
);

    // ------------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------------

    // i/o read or i/o write
    function automatic logic is_io(input logic [3:0] cmd);
        is_io = (cmd == IOWFD_CMD_IO_RD) || (cmd == IOWFD_CMD_IO_WR);
    endfunction

    // any memory command the bridge forwards
    function automatic logic is_mem(input logic [3:0] cmd);
        is_mem = (cmd == IOWFD_CMD_MEM_RD) || (cmd == IOWFD_CMD_MEM_WR) ||
                 (cmd == IOWFD_CMD_MEM_RDM) ||
                 (cmd == IOWFD_CMD_MEM_RDL) ||
                 (cmd == IOWFD_CMD_MEM_WRI);
    endfunction

    // inclusive window compare; base above limit never matches
    function automatic logic in_window(input logic [31:0] addr,
                                       input logic [31:0] base,
                                       input logic [31:0] limit);
        in_window = (addr >= base) && (addr <= limit);
    endfunction

    // isa hole: top 768 bytes of a 1KB block inside the first 64KB
    function automatic logic isa_hole(input logic [31:0] addr,
                                      input logic isa_en);
        logic low64k;
        logic upper3q;
        low64k = (addr[31:IOWFD_UPPER_LSB] ==
                  IOWFD_LOW64K_UPPER);
        upper3q = (addr[IOWFD_ISA_HI:IOWFD_ISA_LO] != 2'b00);
        isa_hole = isa_en && low64k && upper3q;
    endfunction

    // ------------------------------------------------------------------
    // window register file
    // ------------------------------------------------------------------
    iowfd_cfg_if cfg_bus ();

    // hand the configuration port to the register file
    assign cfg_bus.wr = cfg_wr_in;
    assign cfg_bus.rd = cfg_rd_in;
    assign cfg_bus.addr = cfg_addr_in;
    assign cfg_bus.be = cfg_be_in;
    assign cfg_bus.wdata = cfg_wdata_in;

    iowfd_window_regs u_regs (
        .mclk_in(mclk_in),
        .srst_in(srst_in),
        .cfg(cfg_bus)
    );

    // read answer comes from the register file flip-flops
    assign cfg_rdata_out = cfg_bus.rdata;
    assign cfg_rack_out = cfg_bus.rack;
    assign cfg_rhit_out = cfg_bus.rhit;

    // ------------------------------------------------------------------
    // address-phase compare, combinational
    // ------------------------------------------------------------------
    logic [31:0] p_addr32;
    logic [31:0] s_addr32;
    logic p_in_win;
    logic s_in_win;
    logic p_hole;
    logic s_hole;
    logic p_is_io;
    logic s_is_io;
    logic s_is_mem;

    // widen the bus address to the compare width
    assign p_addr32 = 32'(p_addr_in);
    assign s_addr32 = 32'(s_addr_in);

    // window and isa compares on both buses
    assign p_in_win = in_window(p_addr32, cfg_bus.base_addr,
                                cfg_bus.limit_addr);
    assign s_in_win = in_window(s_addr32, cfg_bus.base_addr,
                                cfg_bus.limit_addr);
    assign p_hole = isa_hole(p_addr32, isa_enable_in);
    assign s_hole = isa_hole(s_addr32, isa_enable_in);

    // command classes
    assign p_is_io = is_io(p_cmd_in);
    assign s_is_io = is_io(s_cmd_in);
    assign s_is_mem = is_mem(s_cmd_in);

    // ------------------------------------------------------------------
    // primary decision stage
    // ------------------------------------------------------------------
    logic p_dec_valid_reg, p_dec_valid_next;
    logic p_claim_reg, p_claim_next;
    logic p_isa_excl_reg, p_isa_excl_next;
    logic [ADDR_W-1:0] p_fwd_addr_reg, p_fwd_addr_next;
    logic [3:0] p_fwd_cmd_reg, p_fwd_cmd_next;

    // downstream claim: enabled i/o inside the window, outside isa holes
    always_comb begin
        p_dec_valid_next = p_addr_valid_in;
        p_claim_next = p_claim_reg;
        p_isa_excl_next = p_isa_excl_reg;
        p_fwd_addr_next = p_fwd_addr_reg;
        p_fwd_cmd_next = p_fwd_cmd_reg;
        if (p_addr_valid_in) begin
            p_claim_next = io_enable_in && p_is_io && p_in_win &&
                           !p_hole;
            p_isa_excl_next = p_is_io && p_in_win && p_hole;
            p_fwd_addr_next = p_addr_in;
            p_fwd_cmd_next = p_cmd_in;
        end
        if (srst_in) begin
            p_dec_valid_next = 1'b0;
            p_claim_next = 1'b0;
            p_isa_excl_next = 1'b0;
            p_fwd_addr_next = '0;
            p_fwd_cmd_next = 4'h0;
        end
    end

    // primary registers
    always_ff @(posedge mclk_in) begin
        p_dec_valid_reg <= p_dec_valid_next;
        p_claim_reg <= p_claim_next;
        p_isa_excl_reg <= p_isa_excl_next;
        p_fwd_addr_reg <= p_fwd_addr_next;
        p_fwd_cmd_reg <= p_fwd_cmd_next;
    end

    // ------------------------------------------------------------------
    // secondary decision stage
    // ------------------------------------------------------------------
    logic s_dec_valid_reg, s_dec_valid_next;
    logic s_claim_reg, s_claim_next;
    logic s_mem_pass_reg, s_mem_pass_next;
    logic s_isa_excl_reg, s_isa_excl_next;
    logic [ADDR_W-1:0] s_fwd_addr_reg, s_fwd_addr_next;
    logic [3:0] s_fwd_cmd_reg, s_fwd_cmd_next;

    // upstream claim: for i/o, the address complement of the downstream set, gated by master enable instead of i/o enable
    always_comb begin
        s_dec_valid_next = s_addr_valid_in;
        s_claim_next = s_claim_reg;
        s_mem_pass_next = s_mem_pass_reg;
        s_isa_excl_next = s_isa_excl_reg;
        s_fwd_addr_next = s_fwd_addr_reg;
        s_fwd_cmd_next = s_fwd_cmd_reg;
        if (s_addr_valid_in) begin
            s_claim_next = master_enable_in && s_is_io &&
                           (!s_in_win || s_hole);
            // memory ranges are judged elsewhere; only the enable gate here
            s_mem_pass_next = master_enable_in && s_is_mem;
            s_isa_excl_next = s_is_io && s_in_win && s_hole;
            s_fwd_addr_next = s_addr_in;
            s_fwd_cmd_next = s_cmd_in;
        end
        if (srst_in) begin
            s_dec_valid_next = 1'b0;
            s_claim_next = 1'b0;
            s_mem_pass_next = 1'b0;
            s_isa_excl_next = 1'b0;
            s_fwd_addr_next = '0;
            s_fwd_cmd_next = 4'h0;
        end
    end

    // secondary registers
    always_ff @(posedge mclk_in) begin
        s_dec_valid_reg <= s_dec_valid_next;
        s_claim_reg <= s_claim_next;
        s_mem_pass_reg <= s_mem_pass_next;
        s_isa_excl_reg <= s_isa_excl_next;
        s_fwd_addr_reg <= s_fwd_addr_next;
        s_fwd_cmd_reg <= s_fwd_cmd_next;
    end

    // ------------------------------------------------------------------
    // window status
    // ------------------------------------------------------------------
    logic win_open_reg, win_open_next;

    // window is live only while base does not exceed limit
    always_comb begin
        win_open_next = (cfg_bus.base_addr <= cfg_bus.limit_addr);
        if (srst_in) begin
            win_open_next = 1'b0;
        end
    end

    // status register
    always_ff @(posedge mclk_in) begin
        win_open_reg <= win_open_next;
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign p_dec_valid_out = p_dec_valid_reg;
    assign p_claim_out = p_claim_reg;
    assign p_isa_excl_out = p_isa_excl_reg;
    assign p_fwd_addr_out = p_fwd_addr_reg;
    assign p_fwd_cmd_out = p_fwd_cmd_reg;
    assign s_dec_valid_out = s_dec_valid_reg;
    assign s_claim_out = s_claim_reg;
    assign s_mem_pass_out = s_mem_pass_reg;
    assign s_isa_excl_out = s_isa_excl_reg;
    assign s_fwd_addr_out = s_fwd_addr_reg;
    assign s_fwd_cmd_out = s_fwd_cmd_reg;
    assign win_open_out = win_open_reg;

endmodule
`default_nettype wire

/* sim/iowfd_decoder_chk.sv */
/*
 * checker of decision timing, enable gating and isa holes.
 * assumes it is bound onto iowfd_decoder, one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module iowfd_decoder_chk
    import iowfd_pkg::*;
#(
    parameter int ADDR_W = 32
)
(
    // clock, reset and config port
    input wire logic mclk_in,
    input wire logic srst_in,
    input wire logic cfg_rd_in,
    input wire logic [7:0] cfg_addr_in,
    input wire logic [31:0] cfg_rdata_out,
    input wire logic cfg_rack_out,
    // enables and window status
    input wire logic io_enable_in,
    input wire logic master_enable_in,
    input wire logic isa_enable_in,
    input wire logic win_open_out,
    // primary bus
    input wire logic p_addr_valid_in,
    input wire logic [ADDR_W-1:0] p_addr_in,
    input wire logic [3:0] p_cmd_in,
    input wire logic p_dec_valid_out,
    input wire logic p_claim_out,
    input wire logic [ADDR_W-1:0] p_fwd_addr_out,
    // secondary bus
    input wire logic s_addr_valid_in,
    input wire logic [ADDR_W-1:0] s_addr_in,
    input wire logic [3:0] s_cmd_in,
    input wire logic s_claim_out,
    input wire logic s_mem_pass_out
);
    // ---------------------------------------------------------------
    // helpers: i/o command and isa hole per bus
    // ---------------------------------------------------------------
    logic p_io;
    logic s_io;
    logic p_hole;
    logic s_hole;
    assign p_io = p_cmd_in == IOWFD_CMD_IO_RD || p_cmd_in == IOWFD_CMD_IO_WR;
    assign s_io = s_cmd_in == IOWFD_CMD_IO_RD || s_cmd_in == IOWFD_CMD_IO_WR;
    assign p_hole = p_addr_in[31:16] == 16'h0000 && p_addr_in[9:8] != 2'h0;
    assign s_hole = s_addr_in[31:16] == 16'h0000 && s_addr_in[9:8] != 2'h0;

    default clocking @(posedge mclk_in); endclocking
    default disable iff (srst_in);

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    a_pdec_latency: assert property (p_addr_valid_in |=>
        p_dec_valid_out)
        else $error("primary decision late");
    a_pdec_only: assert property (!p_addr_valid_in |=>
        !p_dec_valid_out)
        else $error("primary decision without address phase");
    a_paddr_pass: assert property (p_addr_valid_in |=>
        p_fwd_addr_out == $past(p_addr_in))
        else $error("primary address altered");
    a_p_io_off: assert property (p_addr_valid_in &&
        !(io_enable_in && p_io) |=> !p_claim_out)
        else $error("primary claimed with i/o disabled");
    a_s_master_off: assert property (s_addr_valid_in &&
        !master_enable_in |=> !s_claim_out && !s_mem_pass_out)
        else $error("secondary forwarded with master disabled");
    a_p_isa_hole: assert property (p_addr_valid_in &&
        isa_enable_in && p_hole |=> !p_claim_out)
        else $error("isa hole forwarded downstream");
    a_s_isa_up: assert property (s_addr_valid_in &&
        master_enable_in && isa_enable_in && s_io && s_hole |=> s_claim_out)
        else $error("isa hole not forwarded upstream");
    a_low_nibbles: assert property (cfg_rd_in &&
        cfg_addr_in[7:2] == 6'h07 |=> cfg_rack_out &&
        cfg_rdata_out[3:0] == 4'h1 && cfg_rdata_out[11:8] == 4'h1)
        else $error("low nibbles not 1h");
    a_reset_window: assert property ($fell(srst_in) |=>
        win_open_out)
        else $error("default window not open after reset");

    // covers of main scenarios
    c_p_claim: cover property (p_dec_valid_out && p_claim_out);
    c_s_claim: cover property (s_claim_out && !s_mem_pass_out);
    c_isa_hole: cover property (p_addr_valid_in && isa_enable_in && p_hole);
endmodule

bind iowfd_decoder iowfd_decoder_chk #(.ADDR_W(ADDR_W)) iowfd_decoder_chk_inst (.*);
`default_nettype wire

/* sim/iowfd_initiator_model.sv */
/*
 * initiator model for one bus: turns a go request into a one-cycle
 * address phase. assumes go is raised for one cycle per transaction.
 */
`timescale 1ns/1ps
`default_nettype none
module iowfd_initiator_model (
    // clock and request
    input wire logic mclk_in,
    input wire logic go_in,
    input wire logic [31:0] addr_in,
    input wire logic [3:0] cmd_in,
    // address phase
    output logic valid_out,
    output logic [31:0] addr_out,
    output logic [3:0] cmd_out
);
    // idle bus lines toggle so a stale address never looks valid
    always_ff @(posedge mclk_in) begin
        valid_out <= go_in;
        addr_out <= go_in ? addr_in : ~addr_out;
        cmd_out <= go_in ? cmd_in : ~cmd_out;
    end
endmodule
`default_nettype wire

/* sim/iowfd_decoder_tb.sv */
/*
 * testbench: config port and forwarding decisions of the decoder.
 * assumes one initiator model in front of each bus.
 */
`timescale 1ns/1ps
`default_nettype none
module iowfd_decoder_tb import iowfd_pkg::*;;
    logic mclk_in = 0, srst_in = 1, wr = 0, rd = 0, pgo = 0, sgo = 0;
    logic ioen = 0, men = 0, isa = 0, rack, rhit, pv, sv, win;
    logic pdv, pcl, pex, sdv, scl, smp, sex;
    logic [7:0] ca = 0;
    logic [3:0] be = 0, rc = 0, pc, sc, pfc, sfc;
    logic [31:0] wd = 0, ra = 0, rdat, pa, sa, pfa, sfa;
    logic [31:0] base_m = 0, lim_m = 32'h0000_0fff;
    int error_cnt = 0, comparisons = 0;
    logic [31:0] at [14] = '{32'h0, 32'hfff, 32'h1000, 32'h3fff, 32'h4000,
        32'h40ff, 32'h4100, 32'h43ff, 32'h4400, 32'h4cff, 32'h4fff,
        32'h5000, 32'h1_4000, 32'h1_0300};
    logic [3:0] ct [7] = '{4'h2, 4'h3, 4'h6, 4'h7, 4'hc, 4'he, 4'hf};

    always #20 mclk_in = ~mclk_in;

    // -----------------------------------------------------------------
    // design and bus initiators
    // -----------------------------------------------------------------
    iowfd_initiator_model p_init_inst (.mclk_in(mclk_in), .go_in(pgo),
        .addr_in(ra), .cmd_in(rc), .valid_out(pv), .addr_out(pa),
        .cmd_out(pc));
    iowfd_initiator_model s_init_inst (.mclk_in(mclk_in), .go_in(sgo),
        .addr_in(ra), .cmd_in(rc), .valid_out(sv), .addr_out(sa),
        .cmd_out(sc));
    iowfd_decoder iowfd_decoder_inst (.mclk_in(mclk_in),
        .srst_in(srst_in), .cfg_wr_in(wr), .cfg_rd_in(rd),
        .cfg_addr_in(ca), .cfg_be_in(be), .cfg_wdata_in(wd),
        .cfg_rdata_out(rdat), .cfg_rack_out(rack), .cfg_rhit_out(rhit),
        .io_enable_in(ioen), .master_enable_in(men),
        .isa_enable_in(isa), .p_addr_valid_in(pv), .p_addr_in(pa),
        .p_cmd_in(pc), .p_dec_valid_out(pdv), .p_claim_out(pcl),
        .p_isa_excl_out(pex), .p_fwd_addr_out(pfa), .p_fwd_cmd_out(pfc),
        .s_addr_valid_in(sv), .s_addr_in(sa), .s_cmd_in(sc),
        .s_dec_valid_out(sdv), .s_claim_out(scl), .s_mem_pass_out(smp),
        .s_isa_excl_out(sex), .s_fwd_addr_out(sfa), .s_fwd_cmd_out(sfc),
        .win_open_out(win));

    // -----------------------------------------------------------------
    // tasks
    // -----------------------------------------------------------------
    task automatic print_verdict();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // compare one value, report and count a mismatch
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cfg_write(input logic [7:0] a, input logic [3:0] b,
                             input logic [31:0] d);
        @(posedge mclk_in);
        #1 ca = a;
        be = b;
        wd = d;
        wr = 1;
        @(posedge mclk_in);
        #1 wr = 0;
    endtask

    // read answer stands one cycle after the strobe
    task automatic cfg_read(input logic [7:0] a, input logic [31:0] exp,
                            input logic hit);
        @(posedge mclk_in);
        #1 ca = a;
        rd = 1;
        @(posedge mclk_in);
        #1 rd = 0;
        chk(32'(rack), 32'h1);
        chk(rdat, exp);
        chk(32'(rhit), 32'(hit));
    endtask

    // program the whole window and track it in the model
    task automatic set_win(input logic [31:0] b, input logic [31:0] l);
        cfg_write(8'h1c, 4'h3, {16'h0, l[15:12], 4'h0, b[15:12], 4'h0});
        cfg_write(8'h30, 4'hf, {l[31:16], b[31:16]});
        base_m = {b[31:12], 12'h000};
        lim_m = {l[31:12], 12'hfff};
    endtask

    // one address phase on a bus, decision compared to the model
    task automatic decide(input logic sec, input logic [31:0] a,
                          input logic [3:0] c);
        logic io, inw, hole, dv;
        int n;
        io = c == IOWFD_CMD_IO_RD || c == IOWFD_CMD_IO_WR;
        inw = base_m <= a && a <= lim_m;
        hole = isa && a[31:16] == 16'h0 && a[9:8] != 2'h0;
        ra = a;
        rc = c;
        if (sec) sgo = 1;
        else pgo = 1;
        @(posedge mclk_in);
        #1 pgo = 0;
        sgo = 0;
        dv = 0;
        for (n = 0; n < 8 && !dv; n++) begin
            @(posedge mclk_in);
            #1 dv = (sec ? sdv : pdv) === 1'b1;
        end
        if (!dv) begin
            error_cnt++;
            print_verdict();
        end
        if (sec) begin
            chk(32'(scl), 32'(men && io && (!inw || hole)));
            chk(32'(smp), 32'(men && !io));
            chk(sfa, a);
            chk(32'(sfc), 32'(c));
            if (io) chk(32'(sex), 32'(inw && hole));
        end else begin
            chk(32'(pcl), 32'(ioen && io && inw && !hole));
            chk({pfc, pfa[27:0]}, {c, a[27:0]});
            if (io) chk(32'(pex), 32'(inw && hole));
        end
    endtask

    // every address of the table on both buses, isa off and on
    task automatic sweep();
        for (int i = 0; i < 4; i++) begin
            isa = i[1];
            foreach (at[k]) decide(i[0], at[k], ct[k % 2]);
        end
    endtask

    // -----------------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------------
    initial begin
        repeat (6) @(posedge mclk_in);
        #1 srst_in = 0;
        @(posedge mclk_in);
        #1 chk(32'(win), 32'h1);
        cfg_read(8'h1c, 32'h0000_0101, 1);
        cfg_read(8'h30, 32'h0, 1);
        cfg_read(8'h20, 32'h0, 0);
        cfg_write(8'h30, 4'hc, 32'habcd_1234);
        cfg_read(8'h30, 32'habcd_0000, 1);
        cfg_write(8'h1c, 4'h1, 32'h0000_ff70);
        cfg_read(8'h1c, 32'h0000_0171, 1);
        set_win(32'h0, 32'h0fff);
        ioen = 1;
        men = 1;
        sweep();
        set_win(32'h4000, 32'h4fff);
        sweep();
        for (int e = 0; e < 4; e++) begin
            ioen = e[0];
            men = e[1];
            foreach (ct[k]) decide(0, 32'h4000, ct[k]);
            foreach (ct[k]) decide(1, 32'h5000, ct[k]);
        end
        ioen = 1;
        men = 1;
        set_win(32'h1_0000, 32'h1_4fff);
        sweep();
        set_win(32'h5000, 32'h4fff);
        @(posedge mclk_in);
        #1 chk(32'(win), 32'h0);
        sweep();
        print_verdict();
    end
endmodule
`default_nettype wire
